// ### core/lpm_cfg.svh
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
// Wake sources of stop mode: I/O lines plus the supply detector
`define LPM_EXT_LINES 16
// Cycles the standby reset pulse is held
`define LPM_STANDBY_RST_CYCLES 4
// Low-power run clock ceiling and the system clock rate
`define LPM_LP_CLK_MAX_HZ 2000000
`define LPM_SYS_CLK_HZ 20000000
`endif

// ### core/lpm_pkg.sv
package lpm_pkg;
	// Power modes of the controller
	typedef enum logic [2:0] {
		run,
		lp_run,
		sleep,
		lp_sleep,
		stop,
		deep_stop,
		standby
	} power_mode_t;

	// Clock and supply enables driven to the clock tree and regulator
	typedef struct packed {
		logic cpu_clk_en;
		logic core_clks_en;
		logic pll_en;
		logic ext_fast_osc_en;
		logic int_fast_osc_en;
		logic int_slow_osc_en;
		logic ext_slow_osc_en;
		logic reg_low_power;
		logic reg_deep_low_power;
		logic reg_off;
		logic core_supply_on;
		logic sysclk_from_int_fast;
	} power_ctrl_t;

	// Control bits written by software
	typedef struct packed {
		logic low_power_run_bit;
		logic power_down_deepsleep_bit;
		logic low_power_deepsleep_bit;
		logic core_deep_sleep_bit;
	} power_control_one_t;
endpackage

// ### core/low_power_mode_controller.sv
`timescale 1ns/1ps
`include "lpm_cfg.svh"

module low_power_mode_controller #(
	parameter int LINES = `LPM_EXT_LINES
)(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire lpm_pkg::power_control_one_t ctrl_in,
	input wire logic wait_for_interrupt_instr_in,
	input wire logic wait_for_event_instr_in,
	input wire logic irq_in,
	input wire logic event_in,
	input wire logic [LINES-1:0] external_event_lines_in,
	input wire logic [LINES-1:0] line_wake_en_in,
	input wire logic supply_voltage_detector_in,
	input wire logic detector_wake_en_in,
	input wire logic wake_pin_in,
	input wire logic rtc_alarm_in,
	input wire logic external_reset_pin_n_in,
	input wire logic independent_watchdog_rst_in,
	output lpm_pkg::power_mode_t mode_out,
	output lpm_pkg::power_ctrl_t power_out,
	output logic retention_lost_out,
	output logic standby_rst_n_out
);
	// ------------------------------------------------------------
	// Wake decoding
	// ------------------------------------------------------------
	lpm_pkg::power_mode_t mode;
	lpm_pkg::power_mode_t next_mode;
	logic wait_req;
	logic sleep_by_event;
	logic wake_pin_d;
	logic stop_wake;
	logic standby_wake;
	logic [2:0] rst_cnt;

	assign wait_req = wait_for_interrupt_instr_in | wait_for_event_instr_in;
	// Any enabled line or the enabled detector ends stop
	assign stop_wake = |(external_event_lines_in & line_wake_en_in)
		| (supply_voltage_detector_in & detector_wake_en_in);
	// Rising edge only: a held-high wake pin must not re-wake
	assign standby_wake = (wake_pin_in & ~wake_pin_d) | rtc_alarm_in
		| ~external_reset_pin_n_in | independent_watchdog_rst_in;

	// Wake pin history for edge detection
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			wake_pin_d <= 1'b0;
		else
			wake_pin_d <= wake_pin_in;
	end

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		next_mode = mode;
		case (mode)
			lpm_pkg::run:
			begin
				if (ctrl_in.low_power_run_bit)
					next_mode = lpm_pkg::lp_run;
				else if (wait_req && ctrl_in.core_deep_sleep_bit)
				begin
					if (ctrl_in.power_down_deepsleep_bit)
						next_mode = lpm_pkg::standby;
					else if (ctrl_in.low_power_deepsleep_bit)
						next_mode = lpm_pkg::deep_stop;
					else
						next_mode = lpm_pkg::stop;
				end
				else if (wait_req)
					next_mode = lpm_pkg::sleep;
			end
			lpm_pkg::lp_run:
			begin
				if (!ctrl_in.low_power_run_bit)
					next_mode = lpm_pkg::run;
				else if (wait_req)
					next_mode = lpm_pkg::lp_sleep;
			end
			lpm_pkg::sleep:
			begin
				// Event sleep resumes on events, interrupt sleep on any
				if (sleep_by_event ? event_in : (irq_in | event_in))
					next_mode = lpm_pkg::run;
			end
			lpm_pkg::lp_sleep:
			begin
				if (irq_in || event_in)
					next_mode = lpm_pkg::lp_run;
			end
			lpm_pkg::stop, lpm_pkg::deep_stop:
			begin
				if (irq_in || event_in || stop_wake)
					next_mode = lpm_pkg::run;
			end
			lpm_pkg::standby:
			begin
				// Leaves only via the reset pulse below
				if (rst_cnt == 3'(`LPM_STANDBY_RST_CYCLES))
					next_mode = lpm_pkg::run;
			end
			default:
				next_mode = lpm_pkg::run;
		endcase
	end

	// Mode register
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			mode <= lpm_pkg::run;
		else
			mode <= next_mode;
	end

	// Remember how sleep was entered
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			sleep_by_event <= 1'b0;
		else if (mode == lpm_pkg::run && next_mode == lpm_pkg::sleep)
			sleep_by_event <= wait_for_event_instr_in &
				~wait_for_interrupt_instr_in;
	end

	// ------------------------------------------------------------
	// Standby exit reset
	// ------------------------------------------------------------
	// Counts wake then reset cycles; waking without a reset would run
	// code on lost state, so exit always passes a reset
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rst_cnt <= 3'h0;
		else if (mode != lpm_pkg::standby)
			rst_cnt <= 3'h0;
		else if (rst_cnt != 3'h0 || standby_wake)
			rst_cnt <= rst_cnt + 3'h1;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			standby_rst_n_out <= 1'b1;
		else
			standby_rst_n_out <= !(next_mode == lpm_pkg::standby &&
				(rst_cnt != 3'h0 || standby_wake));
	end

	// Lost flag set on standby entry, cleared when run is left for any mode but standby
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			retention_lost_out <= 1'b0;
		else if (next_mode == lpm_pkg::standby)
			retention_lost_out <= 1'b1;
		else if (mode == lpm_pkg::run && next_mode != lpm_pkg::run)
			retention_lost_out <= 1'b0;
	end

	// ------------------------------------------------------------
	// Clock and supply outputs
	// ------------------------------------------------------------
	// Registered from next_mode so outputs track the mode register
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			mode_out <= lpm_pkg::run;
			power_out <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
				1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
		end
		else
		begin
			mode_out <= next_mode;
			power_out.cpu_clk_en <= next_mode inside
				{lpm_pkg::run, lpm_pkg::lp_run};
			power_out.core_clks_en <= !(next_mode inside {lpm_pkg::stop,
				lpm_pkg::deep_stop, lpm_pkg::standby});
			// PLL and fast external off outside run and sleep
			power_out.pll_en <= next_mode inside
				{lpm_pkg::run, lpm_pkg::sleep};
			power_out.ext_fast_osc_en <= next_mode inside
				{lpm_pkg::run, lpm_pkg::sleep};
			power_out.int_fast_osc_en <= !(next_mode inside
				{lpm_pkg::stop, lpm_pkg::deep_stop, lpm_pkg::standby});
			power_out.int_slow_osc_en <= 1'b1;
			power_out.ext_slow_osc_en <= 1'b1;
			power_out.reg_low_power <= next_mode inside {lpm_pkg::lp_run,
				lpm_pkg::lp_sleep, lpm_pkg::stop};
			power_out.reg_deep_low_power <=
				next_mode == lpm_pkg::deep_stop;
			power_out.reg_off <= next_mode == lpm_pkg::standby;
			power_out.core_supply_on <=
				next_mode != lpm_pkg::standby;
			// After stop only the internal oscillator is ready
			if (mode inside {lpm_pkg::stop, lpm_pkg::deep_stop} &&
				next_mode == lpm_pkg::run)
				power_out.sysclk_from_int_fast <= 1'b1;
			else if (next_mode == lpm_pkg::standby)
				power_out.sysclk_from_int_fast <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_lp_sleep_entry: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::lp_sleep |->
		$past(mode_out) inside {lpm_pkg::lp_run, lpm_pkg::lp_sleep})
		else $error("low-power sleep not entered from low-power run");
	a_lp_sleep_return: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::lp_sleep &&
		irq_in |=> mode_out == lpm_pkg::lp_run)
		else $error("low-power sleep did not return to low-power run");
	a_lp_run_osc: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::lp_run |->
		!power_out.pll_en && !power_out.ext_fast_osc_en &&
		power_out.int_fast_osc_en)
		else $error("oscillators wrong in low-power run");
	a_lp_run_exit: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::lp_run &&
		!ctrl_in.low_power_run_bit |=> mode_out == lpm_pkg::run)
		else $error("low-power run did not exit");
	a_sleep_clocks: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::sleep |->
		!power_out.cpu_clk_en && power_out.core_clks_en &&
		power_out.pll_en)
		else $error("sleep gated more than the cpu clock");
	a_sleep_wake: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::sleep && event_in
		|=> mode_out == lpm_pkg::run)
		else $error("sleep missed wake event");
	a_stop_entry: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::run &&
		!ctrl_in.low_power_run_bit && wait_req &&
		ctrl_in.core_deep_sleep_bit && !ctrl_in.power_down_deepsleep_bit
		&& !ctrl_in.low_power_deepsleep_bit |=>
		mode_out == lpm_pkg::stop && power_out.reg_low_power)
		else $error("stop not entered");
	a_stop_osc_off: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::stop |->
		!power_out.int_fast_osc_en && !power_out.ext_fast_osc_en &&
		!power_out.core_clks_en)
		else $error("stop left a fast clock running");
	a_stop_line_wake: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out inside {lpm_pkg::stop,
		lpm_pkg::deep_stop} && stop_wake |=> mode_out == lpm_pkg::run
		&& power_out.sysclk_from_int_fast)
		else $error("stop ignored wake line");
	a_deep_stop_reg: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::deep_stop |->
		power_out.reg_deep_low_power && !power_out.reg_low_power)
		else $error("deep stop regulator wrong");
	a_standby_power: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::standby |->
		power_out.reg_off && !power_out.core_supply_on &&
		!power_out.pll_en && retention_lost_out)
		else $error("standby supply not cut");
	a_standby_exit: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) mode_out == lpm_pkg::standby &&
		rtc_alarm_in |=> !standby_rst_n_out ##[1:6]
		mode_out == lpm_pkg::run)
		else $error("standby exit without reset");

	c_lp_sleep: cover property (@(posedge clk_in)
		mode_out == lpm_pkg::lp_sleep ##1 mode_out == lpm_pkg::lp_run);
	c_stop_wake: cover property (@(posedge clk_in)
		mode_out == lpm_pkg::stop ##1 mode_out == lpm_pkg::run);
	c_deep_stop: cover property (@(posedge clk_in)
		mode_out == lpm_pkg::deep_stop);
	c_standby_exit: cover property (@(posedge clk_in)
		mode_out == lpm_pkg::standby ##1 mode_out == lpm_pkg::run);
endmodule

// ### tb/lpm_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Core model: wait instructions and wakes
// ----------------------------------------
// Runs from the system clock only; keeping the clock at 2 MHz in the
// low-power modes is left to software, so the model never slows it
module lpm_core_model
(
	input wire logic clk_in,
	output logic wfi_out,
	output logic wfe_out,
	output logic irq_out,
	output logic event_out
);
	logic [3:0] act;

	// One strobe per request: {event, irq, wait for event, wait for irq}
	assign {event_out, irq_out, wfe_out, wfi_out} = act;
	initial act = 4'h0;

	// Held for exactly one clock, changed only on falling edges
	task automatic pulse(input logic [3:0] sel);
		@(negedge clk_in);
		act = sel;
		@(negedge clk_in);
		act = 4'h0;
	endtask
endmodule

// ### tb/low_power_mode_controller_tb_top.sv
`timescale 1ns/1ps
`include "lpm_cfg.svh"

// ----------------------------------------
// Bench for the power mode controller
// ----------------------------------------
module low_power_mode_controller_tb_top;
	logic clk, arst_n, wait_for_interrupt_instr, wait_for_event_instr, irq, evt, svd, svd_en;
	logic wake_pin, rtc, ext_rst_n, independent_watchdog, lost, srst_n;
	logic [15:0] lines, line_en;
	lpm_pkg::power_control_one_t ctrl;
	lpm_pkg::power_mode_t mode;
	lpm_pkg::power_ctrl_t p;
	logic [4:0] osc;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;

	low_power_mode_controller DUT (.clk_in(clk), .arst_n_in(arst_n),
		.ctrl_in(ctrl), .wait_for_interrupt_instr_in(wait_for_interrupt_instr),
		.wait_for_event_instr_in(wait_for_event_instr), .irq_in(irq), .event_in(evt),
		.external_event_lines_in(lines), .line_wake_en_in(line_en),
		.supply_voltage_detector_in(svd), .detector_wake_en_in(svd_en),
		.wake_pin_in(wake_pin), .rtc_alarm_in(rtc),
		.external_reset_pin_n_in(ext_rst_n),
		.independent_watchdog_rst_in(independent_watchdog), .mode_out(mode),
		.power_out(p), .retention_lost_out(lost),
		.standby_rst_n_out(srst_n));

	lpm_core_model core (.clk_in(clk), .wfi_out(wait_for_interrupt_instr), .wfe_out(wait_for_event_instr),
		.irq_out(irq), .event_out(evt));

	// Oscillators: pll, fast external, fast internal, slow int, slow ext
	assign osc = {p.pll_en, p.ext_fast_osc_en, p.int_fast_osc_en,
		p.int_slow_osc_en, p.ext_slow_osc_en};

	// Clock at 20 MHz
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// A hang ends the run here instead of spinning forever
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Low-power run, then low-power sleep and back to low-power run
	task automatic low_power_run();
		ctrl = 4'h8;
		@(negedge clk);
		check(mode, lpm_pkg::lp_run, "lp run");
		check(osc, 5'h07, "lp oscs");
		// Leaving run clears a lost flag left over from standby
		check(lost, 1'b0, "lost clr");
		core.pulse(4'h2);
		check(mode, lpm_pkg::lp_sleep, "lp sleep");
		check(osc, 5'h07, "lps oscs");
		core.pulse(4'h4);
		check(mode, lpm_pkg::lp_run, "lps wake");
		ctrl = 4'h0;
		@(negedge clk);
		check(mode, lpm_pkg::run, "lp exit");
	endtask

	// Sleep entered either way; an irq only wakes the interrupt kind
	task automatic sleep_wake(input logic [3:0] kind);
		lpm_pkg::power_mode_t exp_mode;
		exp_mode = kind[0] ? lpm_pkg::run : lpm_pkg::sleep;
		core.pulse(kind);
		check(mode, lpm_pkg::sleep, "sleep");
		check({p.cpu_clk_en, p.core_clks_en, p.pll_en}, 3'h3,
			"slp clk");
		core.pulse(4'h4);
		check(mode, exp_mode, "irq");
		// Interrupt sleep again, so the event wake is seen in both kinds
		if (kind[0])
			core.pulse(kind);
		core.pulse(4'h8);
		check(mode, lpm_pkg::run, "event");
	endtask

	// Stop or deep stop; source 16 is the supply detector
	task automatic stop_wake(input logic [3:0] c, input int src);
		lpm_pkg::power_mode_t exp_mode;
		exp_mode = c[1] ? lpm_pkg::deep_stop : lpm_pkg::stop;
		ctrl = c;
		core.pulse(4'h1);
		check(mode, exp_mode, "stop");
		check({p.core_clks_en, p.ext_fast_osc_en, p.int_fast_osc_en,
			p.reg_low_power, p.reg_deep_low_power},
			{3'h0, !c[1], c[1]}, "stop pwr");
		{svd, lines} = 17'h1 << src;
		repeat (2) @(negedge clk);
		check(mode, exp_mode, "masked");
		{svd_en, line_en} = 17'h1 << src;
		@(negedge clk);
		check(mode, lpm_pkg::run, "line wake");
		check(p.sysclk_from_int_fast, 1'b1, "int osc");
		{svd, lines, svd_en, line_en} = '0;
		ctrl = 4'h0;
		@(negedge clk);
	endtask

	// Standby and exit through a reset pulse from one of four sources
	task automatic standby_exit(input int src);
		int low;
		low = 0;
		ctrl = 4'h5;
		core.pulse(4'h2);
		check(mode, lpm_pkg::standby, "standby");
		check({p.reg_off, p.core_supply_on, p.pll_en, p.ext_fast_osc_en,
			p.int_fast_osc_en, lost}, 6'h21, "stby pwr");
		core.pulse(4'h4);
		check(mode, lpm_pkg::standby, "irq kept");
		// Exactly one wake source is active for this pass
		wake_pin = (src == 0);
		rtc = (src == 1);
		ext_rst_n = (src != 2);
		independent_watchdog = (src == 3);
		@(negedge clk);
		{wake_pin, rtc, independent_watchdog, ext_rst_n} = 4'h1;
		repeat (12)
		begin
			if (srst_n === 1'b0)
				low++;
			@(negedge clk);
		end
		check(low, `LPM_STANDBY_RST_CYCLES, "rst len");
		check({mode, srst_n, lost}, {lpm_pkg::run, 2'h3},
			"stby out");
		ctrl = 4'h0;
		@(negedge clk);
	endtask

	// A reset in mid-run from standby restores the run defaults at once
	task automatic reset_in_standby();
		ctrl = 4'h5;
		core.pulse(4'h1);
		check(mode, lpm_pkg::standby, "stby again");
		arst_n = 1'b0;
		ctrl = 4'h0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		check({mode, p, lost, srst_n}, {lpm_pkg::run, 12'hfe3, 2'h1},
			"mid rst");
		@(negedge clk);
		check({mode, osc}, {lpm_pkg::run, 5'h1f}, "after rst");
	endtask

	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		ctrl = 4'h0;
		{lines, line_en, svd, svd_en, wake_pin, rtc, independent_watchdog} = '0;
		ext_rst_n = 1'b1;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		check({mode, p, lost, srst_n}, {lpm_pkg::run, 12'hfe3, 2'h1},
			"rst");
		low_power_run();
		sleep_wake(4'h1);
		sleep_wake(4'h2);
		sleep_wake(4'h3);
		stop_wake(4'h1, 0);
		stop_wake(4'h1, 15);
		stop_wake(4'h3, 16);
		for (int s = 0; s < 4; s++)
			standby_exit(s);
		low_power_run();
		reset_in_standby();
		conclude();
	end
endmodule
